// ==== hw/pin_ctrl_pkg.sv ====
// Constants, register map and types for the host status and tamper pin block.
package pin_ctrl_pkg;
    // Clock rate and derived tick.
    localparam int CLK_HZ = 10_000_000;
    localparam int TICK_US = 1;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
    localparam int BOOT_US = 10;
    localparam int BOOT_CYCLES = (CLK_HZ / 1_000_000) * BOOT_US;
    localparam int WD_TIMEOUT_US = 1000;

    // Register byte offsets.
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] PULSE_OFF = 8'h04;
    localparam logic [7:0] TRIG_OFF = 8'h08;
    localparam logic [7:0] CMD_OFF = 8'h0C;
    localparam logic [7:0] STAT_OFF = 8'h10;
    localparam logic [7:0] IRQ_OFF = 8'h14;
    localparam logic [7:0] MASK_OFF = 8'h18;

    // Control fields.
    localparam int CTRL_TAMPER_EN = 0;
    localparam int CTRL_RST_EN = 1;
    localparam int CTRL_RST_POL = 2;
    localparam int CTRL_RST_HOLD = 3;
    localparam int CTRL_WD_EN = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // Command register fields: bit0 start, bit1 done, bit2 event pulse.
    localparam int CMD_START = 0;
    localparam int CMD_DONE = 1;

    // Event numbering, shared by trigger select, irq status and mask.
    localparam int EV_TAMPER = 0;
    localparam int EV_WD = 1;
    localparam int EV_SW = 2;
    localparam int EV_RST_DONE = 3;
    localparam int NUM_EV = 4;
    localparam logic [NUM_EV-1:0] EV_RESET = 4'h0;

    localparam logic [15:0] PULSE_RESET = 16'h000A;

    typedef enum logic [1:0] {
        RDY_BOOT = 2'b00,
        RDY_IDLE = 2'b01,
        RDY_BUSY = 2'b10
    } rdy_state_e;
endpackage

// ==== hw/pin_sync_if.sv ====
// Interface carrying synchronised pin levels between the block's modules.
`timescale 1ns/10ps
interface pin_sync_if;
    logic tamper_n;
    logic wd_kick;
    logic pwr_n;
    modport src (output tamper_n, output wd_kick, output pwr_n);
    modport dst (input tamper_n, input wd_kick, input pwr_n);
endinterface

// ==== hw/pin_sync.sv ====
// Two-flop synchronisers for the asynchronous control pins.
`timescale 1ns/10ps
module pin_sync (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] pins_i,
    pin_sync_if.src sync
);
    logic [2:0] meta_reg;
    logic [2:0] stable_reg;

    // Reset to the idle levels so no false event is seen at release.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= 3'h7;
            stable_reg <= 3'h7;
        end else begin
            meta_reg <= pins_i;
            stable_reg <= meta_reg;
        end
    end

    assign sync.tamper_n = stable_reg[0];
    assign sync.wd_kick = stable_reg[1];
    assign sync.pwr_n = stable_reg[2];
endmodule

// ==== hw/pin_ctrl.sv ====
// Tamper, reset-out, watchdog and ready pin logic with a Wishbone slave.
// Contract
// [RULE1] Tamper counted only when powered and conditions valid.
// [RULE2] Enabled tamper low starts the tamper response.
// [RULE3] Tamper sensing off after reset until enabled.
// [RULE4] Enabled reset output holds or pulses on trigger.
// [RULE5] Reset output disabled by default, never driven.
// [RULE6] Enabled but idle reset output stays undriven.
// [RULE7] Trigger drives reset output at polarity for duration.
// [RULE8] After duration reset output returns undriven.
// [RULE9] Watchdog off by default; input ignored then.
// [RULE10] Ready low while busy or unable to accept.
// [RULE11] Ready high after boot when commands accepted.
// [RULE12] Ready high when command finished, response readable.
// [RULE13] Power-down low clears volatile state; host holds high.
// [RULE14] Tamper input active low, idle high reads untampered.
// [RULE15] Host waits for ready high before commanding.
// [RULE16] Tamper and watchdog inputs synchronised first.
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
module pin_ctrl
    import pin_ctrl_pkg::*;
#(
    parameter int WD_TIMEOUT_CYCLES = (CLK_HZ / 1_000_000) * WD_TIMEOUT_US
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic tamper_in_n_i,
    input wire logic watchdog_kick_input_i,
    input wire logic power_down_input_n_i,
    input wire logic cond_valid_i,
    input wire logic reset_out_i,
    output logic reset_out_o,
    output logic reset_out_oe_o,
    output logic ready_o,
    output logic zeroize_o,
    output logic irq_o
);
    ////////////////////////////////////////////////////////////////////////
    pin_sync_if sync_bus();

    pin_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pins_i({power_down_input_n_i, watchdog_kick_input_i,
            tamper_in_n_i}),
        .sync(sync_bus.src)
    ); // RULE16

    // Power-down acts as a reset for all volatile state except the synchronisers and the bus interface.
    logic clr;
    assign clr = rst_i || !sync_bus.pwr_n; // RULE13

    ////////////////////////////////////////////////////////////////////////
    logic [4:0] ctrl_reg;
    logic [15:0] pulse_reg;
    logic [NUM_EV-1:0] trig_reg;
    logic [NUM_EV-1:0] irq_reg;
    logic [NUM_EV-1:0] mask_reg;
    logic [31:0] rdata;
    logic req;
    logic wr;
    logic wr_ctrl;
    logic wr_pulse;
    logic wr_trig;
    logic wr_cmd;
    logic wr_irq;
    logic wr_mask;
    logic lane0;

    assign req = cyc_i && stb_i && !ack_o;
    assign wr = req && we_i;
    assign lane0 = sel_i[0];
    assign wr_ctrl = wr && lane0 && adr_i == CTRL_OFF;
    assign wr_pulse = wr && adr_i == PULSE_OFF;
    assign wr_trig = wr && lane0 && adr_i == TRIG_OFF;
    assign wr_cmd = wr && lane0 && adr_i == CMD_OFF;
    assign wr_irq = wr && lane0 && adr_i == IRQ_OFF;
    assign wr_mask = wr && lane0 && adr_i == MASK_OFF;

    logic [15:0] pulse_next;
    assign pulse_next = {sel_i[1] ? dat_i[15:8] : pulse_reg[15:8],
        sel_i[0] ? dat_i[7:0] : pulse_reg[7:0]};

    // Control defaults keep every optional pin function off.
    always_ff @(posedge clk_i) begin
        if (clr) begin
            ctrl_reg <= CTRL_RESET; // RULE3 RULE5 RULE9
            pulse_reg <= PULSE_RESET;
            trig_reg <= EV_RESET;
            mask_reg <= EV_RESET;
        end else begin
            if (wr_ctrl)
                ctrl_reg <= dat_i[4:0];
            if (wr_pulse)
                pulse_reg <= pulse_next;
            if (wr_trig)
                trig_reg <= dat_i[NUM_EV-1:0];
            if (wr_mask)
                mask_reg <= dat_i[NUM_EV-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Microsecond tick for the pulse timer.
    logic [7:0] tick_cnt_reg;
    logic tick;
    assign tick = tick_cnt_reg == 8'(TICK_CYCLES - 1);
    always_ff @(posedge clk_i) begin
        if (clr || tick)
            tick_cnt_reg <= 8'h00;
        else
            tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////
    // Tamper: level sensitive, so a held-low sensor keeps firing.
    logic tamper_ev;
    assign tamper_ev = ctrl_reg[CTRL_TAMPER_EN] && !sync_bus.tamper_n
        && cond_valid_i; // RULE1 RULE2 RULE14

    // Watchdog: any kick edge restarts the timeout.
    logic kick_d_reg;
    logic [31:0] wd_cnt_reg;
    logic wd_ev;
    logic kick_edge;
    assign kick_edge = sync_bus.wd_kick != kick_d_reg;
    assign wd_ev = ctrl_reg[CTRL_WD_EN]
        && wd_cnt_reg == 32'(WD_TIMEOUT_CYCLES - 1);
    always_ff @(posedge clk_i) begin
        if (clr)
            kick_d_reg <= 1'b1;
        else
            kick_d_reg <= sync_bus.wd_kick;
    end
    always_ff @(posedge clk_i) begin
        if (clr || !ctrl_reg[CTRL_WD_EN] || kick_edge || wd_ev)
            wd_cnt_reg <= 32'h0000_0000; // RULE9
        else
            wd_cnt_reg <= wd_cnt_reg + 32'h0000_0001;
    end

    logic sw_ev;
    assign sw_ev = wr_cmd && dat_i[EV_SW];

    ////////////////////////////////////////////////////////////////////////
    // Reset-out driver.
    logic [NUM_EV-1:0] ev_vec;
    logic trigger;
    logic active_reg;
    logic [15:0] dur_reg;
    logic done_ev;
    assign ev_vec = {1'b0, sw_ev, wd_ev, tamper_ev};
    assign trigger = ctrl_reg[CTRL_RST_EN] && |(ev_vec & trig_reg);
    assign done_ev = active_reg && !ctrl_reg[CTRL_RST_HOLD] && tick
        && dur_reg <= 16'h0001;

    always_ff @(posedge clk_i) begin
        if (clr || !ctrl_reg[CTRL_RST_EN]) begin
            active_reg <= 1'b0;
            dur_reg <= 16'h0000;
        end else if (trigger) begin
            active_reg <= 1'b1; // RULE4 RULE7
            dur_reg <= pulse_reg;
        end else if (done_ev) begin
            active_reg <= 1'b0; // RULE8
        end else if (active_reg && tick) begin
            dur_reg <= dur_reg - 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (clr) begin
            reset_out_oe_o <= 1'b0;
            reset_out_o <= 1'b0;
        end else begin
            reset_out_oe_o <= active_reg || trigger; // RULE5 RULE6
            reset_out_o <= ctrl_reg[CTRL_RST_POL];
        end
    end

    always_ff @(posedge clk_i) begin
        if (clr)
            zeroize_o <= 1'b0;
        else
            zeroize_o <= tamper_ev;
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready handshake.
    rdy_state_e st_reg;
    rdy_state_e st_next;
    logic [7:0] boot_cnt_reg;
    always_comb begin
        st_next = st_reg;
        case (st_reg)
            RDY_BOOT: begin
                if (boot_cnt_reg == 8'(BOOT_CYCLES - 1))
                    st_next = RDY_IDLE; // RULE11
            end
            RDY_IDLE: begin
                if (wr_cmd && dat_i[CMD_START])
                    st_next = RDY_BUSY; // RULE10
            end
            RDY_BUSY: begin
                if (wr_cmd && dat_i[CMD_DONE])
                    st_next = RDY_IDLE; // RULE12
            end
            default: st_next = RDY_BOOT;
        endcase
    end
    always_ff @(posedge clk_i) begin
        if (clr) begin
            st_reg <= RDY_BOOT;
            boot_cnt_reg <= 8'h00;
            ready_o <= 1'b0;
        end else begin
            st_reg <= st_next;
            if (st_reg == RDY_BOOT)
                boot_cnt_reg <= boot_cnt_reg + 8'h01;
            ready_o <= st_next == RDY_IDLE; // RULE10 RULE11 RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events; a new event in the clearing cycle wins.
    logic [NUM_EV-1:0] ev_all;
    assign ev_all = {done_ev, sw_ev, wd_ev, tamper_ev};
    always_ff @(posedge clk_i) begin
        if (clr)
            irq_reg <= EV_RESET;
        else if (wr_irq)
            irq_reg <= (irq_reg & ~dat_i[NUM_EV-1:0]) | ev_all;
        else
            irq_reg <= irq_reg | ev_all;
    end
    always_ff @(posedge clk_i) begin
        if (clr)
            irq_o <= 1'b0;
        else
            irq_o <= |(irq_reg & mask_reg);
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        rdata = 32'h0000_0000;
        case (adr_i)
            CTRL_OFF: rdata = {27'h0, ctrl_reg};
            PULSE_OFF: rdata = {16'h0, pulse_reg};
            TRIG_OFF: rdata = {28'h0, trig_reg};
            CMD_OFF: rdata = {30'h0, st_reg};
            STAT_OFF: rdata = {26'h0, active_reg, ready_o, reset_out_i,
                sync_bus.wd_kick, sync_bus.tamper_n, zeroize_o};
            IRQ_OFF: rdata = {28'h0, irq_reg};
            MASK_OFF: rdata = {28'h0, mask_reg};
            default: rdata = 32'h0000_0000;
        endcase
    end
    // Bus interface survives power-down only through rst_i.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req;
            dat_o <= req ? rdata : 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    sequence s_trig;
        trigger && !active_reg;
    endsequence

    a_drive_on_trigger: assert property ( // RULE7
        @(posedge clk_i) disable iff (clr)
        s_trig |=> reset_out_oe_o)
        else $error("reset output not driven after trigger");
    a_disabled_undriven: assert property ( // RULE5
        @(posedge clk_i) disable iff (clr)
        !ctrl_reg[CTRL_RST_EN] ##1 !ctrl_reg[CTRL_RST_EN] |=>
        !reset_out_oe_o)
        else $error("reset output driven while disabled");
    a_idle_undriven: assert property ( // RULE6
        @(posedge clk_i) disable iff (clr)
        !active_reg && !trigger |=> !reset_out_oe_o)
        else $error("reset output driven while idle");
    // A fresh trigger right after the release may drive the pin again.
    a_release_after: assert property ( // RULE8
        @(posedge clk_i) disable iff (clr)
        done_ev && !trigger |=> !active_reg ##1
        (!reset_out_oe_o || $past(trigger)))
        else $error("reset output not released");
    a_drive_polarity: assert property ( // RULE7
        @(posedge clk_i) disable iff (clr)
        reset_out_oe_o |-> reset_out_o == $past(ctrl_reg[CTRL_RST_POL]))
        else $error("reset output polarity wrong");
    a_tamper_gate: assert property ( // RULE3
        @(posedge clk_i) disable iff (clr)
        !ctrl_reg[CTRL_TAMPER_EN] |=> !zeroize_o)
        else $error("tamper response while disabled");
    a_tamper_fire: assert property ( // RULE2
        @(posedge clk_i) disable iff (clr)
        tamper_ev |=> zeroize_o && irq_reg[EV_TAMPER])
        else $error("tamper response missing");
    a_tamper_valid: assert property ( // RULE1
        @(posedge clk_i) disable iff (clr)
        !cond_valid_i |=> !zeroize_o)
        else $error("tamper seen in invalid conditions");
    a_wd_ignored: assert property ( // RULE9
        @(posedge clk_i) disable iff (clr)
        !ctrl_reg[CTRL_WD_EN] |=> wd_cnt_reg == 32'h0000_0000)
        else $error("watchdog active while disabled");
    a_busy_not_ready: assert property ( // RULE10
        @(posedge clk_i) disable iff (clr)
        st_reg == RDY_BUSY && $past(st_reg) == RDY_BUSY |-> !ready_o)
        else $error("ready high while busy");
    a_ready_done: assert property ( // RULE12
        @(posedge clk_i) disable iff (clr)
        st_reg == RDY_BUSY && wr_cmd && dat_i[CMD_DONE] |=> ready_o)
        else $error("ready not raised at completion");
    a_boot_ready: assert property ( // RULE11
        @(posedge clk_i) disable iff (clr)
        $rose(st_reg == RDY_IDLE) && $past(st_reg) == RDY_BOOT |-> ready_o)
        else $error("ready not raised after boot");
endmodule

// ==== sim/pin_partner.sv ====
// Far-side model: tamper sensor, host kick line and pulled-up reset wire.
`timescale 1ns/10ps
module pin_partner (
    input wire logic clk_i,
    input wire logic sensor_closed_i,
    input wire logic kick_i,
    input wire logic drive_i,
    input wire logic drive_oe_i,
    output logic tamper_n_o,
    output logic kick_o,
    output logic wire_o
);
    // An open sensor leaves the pin to its pull-up, so it reads untampered.
    assign tamper_n_o = sensor_closed_i ? 1'b0 : 1'b1;
    // Nobody drives the wire while the enable is low; the pull-up wins.
    assign wire_o = drive_oe_i ? drive_i : 1'b1;
    logic toggle_reg = 1'b0;
    assign kick_o = toggle_reg;
    always @(posedge clk_i) begin
        if (kick_i) begin
            toggle_reg <= ~toggle_reg;
        end
    end
endmodule

// ==== sim/test_host_status_and_tamper_pins.sv ====
// Self-checking bench for the host status and tamper pin block.
`timescale 1ns/10ps
module test_host_status_and_tamper_pins;
    import pin_ctrl_pkg::*;
    localparam int WDC = 50;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o, q;
    logic ack_o, reset_out_o, reset_out_oe_o, ready_o, zeroize_o, irq_o;
    logic tamper_n, kick_w, wire_lvl;
    logic sensor = 1'b0;
    logic kick = 1'b0;
    logic pwr_n = 1'b1;
    logic cond = 1'b1;
    logic [31:0] lfsr = 32'h46F4;
    int n_errors = 0;
    int check_count = 0;
    int cnt = 0;
    int n, pol, p;
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cnt <= cnt + 1;
    end
    pin_ctrl #(.WD_TIMEOUT_CYCLES(WDC)) u_pin_ctrl (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .tamper_in_n_i(tamper_n),
        .watchdog_kick_input_i(kick_w), .power_down_input_n_i(pwr_n),
        .cond_valid_i(cond), .reset_out_i(wire_lvl),
        .reset_out_o(reset_out_o), .reset_out_oe_o(reset_out_oe_o),
        .ready_o(ready_o), .zeroize_o(zeroize_o), .irq_o(irq_o));
    pin_partner u_pin_partner (
        .clk_i(clk_i), .sensor_closed_i(sensor), .kick_i(kick),
        .drive_i(reset_out_o), .drive_oe_i(reset_out_oe_o),
        .tamper_n_o(tamper_n), .kick_o(kick_w), .wire_o(wire_lvl));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    // The request is held until ack is sampled; the extra edge keeps one
    // idle cycle between requests.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        chk(k < 20, 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic boot_chk;
        int t0;
        t0 = cnt;
        chk(ready_o, 1'b0);
        rd(CMD_OFF, 32'h0);
        while (ready_o !== 1'b1 && cnt - t0 < 300) begin
            @(posedge clk_i);
        end
        chk(cnt - t0 >= BOOT_CYCLES, 1);
        chk(cnt - t0 <= BOOT_CYCLES + 6, 1);
        rd(CMD_OFF, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(30000 * 100);
        n_errors++;
        wrap_up();
    end
    initial begin
        tick(8);
        rst_i <= 1'b0;
        boot_chk();
        rd(CTRL_OFF, 32'h0);
        rd(PULSE_OFF, {16'h0, PULSE_RESET});
        rd(8'h1C, 32'h0);
        sensor <= 1'b1;
        tick(10);
        chk(zeroize_o, 1'b0);
        rd(IRQ_OFF, 32'h0);
        cond <= 1'b0;
        wb(1'b1, CTRL_OFF, 32'h1);
        tick(6);
        chk(zeroize_o, 1'b0);
        rd(IRQ_OFF, 32'h0);
        cond <= 1'b1;
        tick(4);
        chk(zeroize_o, 1'b1);
        sensor <= 1'b0;
        tick(4);
        chk(zeroize_o, 1'b0);
        rd(IRQ_OFF, 32'h1);
        chk(irq_o, 1'b0);
        wb(1'b1, MASK_OFF, 32'h1);
        tick(2);
        chk(irq_o, 1'b1);
        wb(1'b1, IRQ_OFF, 32'h1);
        tick(2);
        chk(irq_o, 1'b0);
        // Powered down, the pin is ignored and all state outside the synchronisers and the bus interface is lost.
        pwr_n <= 1'b0;
        sensor <= 1'b1;
        tick(6);
        chk(zeroize_o, 1'b0);
        chk(ready_o, 1'b0);
        pwr_n <= 1'b1;
        sensor <= 1'b0;
        boot_chk();
        rd(CTRL_OFF, 32'h0);
        wb(1'b1, TRIG_OFF, 32'h4);
        wb(1'b1, CMD_OFF, 32'h4);
        tick(3);
        chk(reset_out_oe_o, 1'b0);
        chk(wire_lvl, 1'b1);
        for (pol = 0; pol < 2; pol++) begin
            lfsr = next_rand(lfsr);
            p = 2 + lfsr[2:0];
            wb(1'b1, PULSE_OFF, p);
            wb(1'b1, CTRL_OFF, 32'h2 | (pol << 2));
            tick(3);
            chk(reset_out_oe_o, 1'b0);
            wb(1'b1, CMD_OFF, 32'h4);
            chk(reset_out_oe_o, 1'b1);
            chk(wire_lvl, pol);
            n = 0;
            while (reset_out_oe_o === 1'b1 && n < 400) begin
                @(posedge clk_i);
                n++;
            end
            chk(n >= (p - 1) * TICK_CYCLES, 1);
            chk(n <= (p + 1) * TICK_CYCLES, 1);
            chk(wire_lvl, 1'b1);
        end
        rd(IRQ_OFF, 32'hC);
        wb(1'b1, CTRL_OFF, 32'hA);
        wb(1'b1, CMD_OFF, 32'h4);
        tick(120);
        chk(reset_out_oe_o, 1'b1);
        rd(STAT_OFF, 32'h32);
        wb(1'b1, CTRL_OFF, 32'h0);
        tick(2);
        chk(reset_out_oe_o, 1'b0);
        wb(1'b1, IRQ_OFF, 32'hF);
        tick(WDC * 3);
        wb(1'b0, IRQ_OFF, 32'h0);
        chk(q[EV_WD], 1'b0);
        wb(1'b1, CTRL_OFF, 32'h10);
        for (n = 0; n < 10; n++) begin
            kick <= 1'b1;
            @(posedge clk_i);
            kick <= 1'b0;
            tick(WDC / 3);
        end
        wb(1'b0, IRQ_OFF, 32'h0);
        chk(q[EV_WD], 1'b0);
        tick(WDC * 2);
        wb(1'b0, IRQ_OFF, 32'h0);
        chk(q[EV_WD], 1'b1);
        while (ready_o !== 1'b1) begin
            @(posedge clk_i);
        end
        wb(1'b1, CMD_OFF, 32'h1);
        chk(ready_o, 1'b0);
        rd(CMD_OFF, 32'h2);
        wb(1'b1, CMD_OFF, 32'h2);
        chk(ready_o, 1'b1);
        rd(CMD_OFF, 32'h1);
        wrap_up();
    end
endmodule
